// ===== core/kwp_pkg.sv
// constants and state type for the port f keypad interrupt block
package kwp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] KWP_IDX_STATUS_CONTROL = 8'h40;
    localparam logic [7:0] KWP_IDX_PIN_ENABLE     = 8'h41;
    localparam logic [7:0] KWP_IDX_PULLUP_ENABLE  = 8'h42;

    // bus geometry
    localparam int KWP_ADDR_W   = 10;
    localparam int KWP_DATA_W   = 32;
    localparam int KWP_PINS     = 8;
    localparam int KWP_IDX_LSB  = 2;

    // keypad_status_control field positions
    localparam int KWP_BIT_MODE = 0;
    localparam int KWP_BIT_MASK = 1;
    localparam int KWP_BIT_ACK  = 2;
    localparam int KWP_BIT_FLAG = 3;

    // reset values
    localparam logic [7:0] KWP_RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] KWP_RST_PULLUP     = 8'hff;
    localparam logic [7:0] KWP_ZERO_BYTE      = 8'h00;
    localparam logic [KWP_DATA_W-1:0] KWP_ZERO_WORD = 32'h0000_0000;

    // interrupt vector location served on this request
    localparam logic [15:0] KWP_VECTOR_HI = 16'hffe8;
    localparam logic [15:0] KWP_VECTOR_LO = 16'hffe9;

    // whole block state, registered as one word
    typedef struct packed {
        logic [7:0]  pin_sync1;
        logic [7:0]  pin_sync2;
        logic        prev_low_any;
        logic        pending;
        logic        acked;
        logic        irq_mask;
        logic        trigger_level_select;
        logic [7:0]  pin_irq_enable;
        logic [7:0]  pin_pullup_enable;
        logic        bus_ack;
        logic [31:0] readdata;
    } kwp_state_t;

endpackage

// ===== core/kwp_top.sv
// port f keypad interrupt logic with avalon-mm register slave
`timescale 1ns/100ps

// How it works
// - each pin enable independently forces pin input
// - pin enable never touches its pull-up
// - latch when enabled pin falls, all high before
// - edge mode ignores edge while another low
// - level mode holds request while any low
// - level mode clears after ack and all-high
// - edge mode ack clears request at once
// - ack bit pulses acknowledge, reads zero
// - falling edge after ack latches again
// - unmasked request interrupts, vector fetch acknowledges
// - pending flag mirrors latch regardless of mask
// - mask blocks interrupt, latch still works
// - reset clears latch, flag, mask, mode, pin enables
// - status bits seven to four read zero
// - pull-ups reset on, zero disables
// - request wakes from wait when unmasked
// - request wakes from stop when unmasked
// - break with clear-enable low blocks ack write
// - break with clear-enable high lets ack clear
module kwp_top
    import kwp_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    input  wire logic [KWP_ADDR_W-1:0] address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [KWP_DATA_W-1:0] writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [KWP_DATA_W-1:0] readdata,
    output logic                       waitrequest,
    input  wire logic [KWP_PINS-1:0]   key_pin_in,
    output logic      [KWP_PINS-1:0]   pin_input_force,
    output logic      [KWP_PINS-1:0]   pin_pullup_enable,
    input  wire logic                  break_state,
    input  wire logic                  break_clear_enable,
    input  wire logic                  vector_fetch_ack,
    output logic                       keypad_irq,
    output logic                       wakeup_req
);

    kwp_state_t r;
    kwp_state_t n;

    logic [7:0] idx;
    logic       req;
    logic       hit_scr;
    logic       hit_en;
    logic       hit_pu;
    logic       wr_take;
    logic [7:0] wbyte;
    logic [7:0] low_pins;
    logic       low_any;
    logic       falling;
    logic       sw_ack;
    logic       ack_ev;
    logic [7:0] scr_read;

    // decode; one wait state before every answer
    assign idx     = address[KWP_ADDR_W-1:KWP_IDX_LSB];
    assign req     = read | write;
    assign hit_scr = (idx == KWP_IDX_STATUS_CONTROL);
    assign hit_en  = (idx == KWP_IDX_PIN_ENABLE);
    assign hit_pu  = (idx == KWP_IDX_PULLUP_ENABLE);
    assign wr_take = write & r.bus_ack & byteenable[0];
    assign wbyte   = writedata[7:0];

    // pin activity on synchronised levels only
    assign low_pins = r.pin_irq_enable & ~r.pin_sync2;
    assign low_any  = |low_pins;
    assign falling  = low_any & ~r.prev_low_any;

    // software ack is gated during break unless clear is allowed
    assign sw_ack = wr_take & hit_scr & wbyte[KWP_BIT_ACK]
                    & (~break_state | break_clear_enable);
    assign ack_ev = sw_ack | vector_fetch_ack;

    // status byte: upper nibble and ack always zero
    assign scr_read = {4'h0, r.pending, 1'b0, r.irq_mask,
                       r.trigger_level_select};

    // next-state logic
    always_comb begin
        n = r;
        n.pin_sync1    = key_pin_in;
        n.pin_sync2    = r.pin_sync1;
        n.prev_low_any = low_any;
        // request latch; a new edge always wins over a clear
        if (falling) begin
            n.pending = 1'b1;
            n.acked   = 1'b0;
        end else if (r.trigger_level_select) begin
            // level mode needs both the ack and all pins high
            if (r.pending && (ack_ev || r.acked) && !low_any) begin
                n.pending = 1'b0;
                n.acked   = 1'b0;
            end else if (r.pending && ack_ev) begin
                n.acked = 1'b1;
            end
            if (low_any) begin
                n.pending = 1'b1;
            end
        end else if (ack_ev) begin
            n.pending = 1'b0;
            n.acked   = 1'b0;
        end
        // register writes take effect on the accepting edge
        if (wr_take && hit_scr) begin
            n.irq_mask             = wbyte[KWP_BIT_MASK];
            n.trigger_level_select = wbyte[KWP_BIT_MODE];
        end
        if (wr_take && hit_en) begin
            n.pin_irq_enable = wbyte;
        end
        if (wr_take && hit_pu) begin
            n.pin_pullup_enable = wbyte;
        end
        // answer handshake and read capture
        n.bus_ack = req & ~r.bus_ack;
        if (req && !r.bus_ack) begin
            unique case (1'b1)
                hit_scr: n.readdata = {24'h000000, scr_read};
                hit_en:  n.readdata = {24'h000000, r.pin_irq_enable};
                hit_pu:  n.readdata = {24'h000000, r.pin_pullup_enable};
                default: n.readdata = KWP_ZERO_WORD;
            endcase
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            r.pin_sync1            <= KWP_ZERO_BYTE;
            r.pin_sync2            <= KWP_ZERO_BYTE;
            r.prev_low_any         <= 1'b0;
            r.pending              <= 1'b0;
            r.acked                <= 1'b0;
            r.irq_mask             <= 1'b0;
            r.trigger_level_select <= 1'b0;
            r.pin_irq_enable       <= KWP_RST_PIN_ENABLE;
            r.pin_pullup_enable    <= KWP_RST_PULLUP;
            r.bus_ack              <= 1'b0;
            r.readdata             <= KWP_ZERO_WORD;
        end else begin
            r <= n;
        end
    end

    // outputs
    assign readdata          = r.readdata;
    assign waitrequest       = req & ~r.bus_ack;
    assign pin_input_force   = r.pin_irq_enable;
    assign pin_pullup_enable = r.pin_pullup_enable;
    assign keypad_irq        = r.pending & ~r.irq_mask;
    // raw pin path keeps the wake request alive with the clock stopped
    assign wakeup_req = ~r.irq_mask
                        & (r.pending
                           | (|(r.pin_irq_enable & ~key_pin_in)));

    // checks on the block's own behaviour
    property p_edge_latch;
        @(posedge ref_clk) disable iff (rst)
        falling |=> r.pending;
    endproperty
    a_edge_latch: assert property (p_edge_latch)
        else $error("falling edge did not latch a request");

    property p_edge_blocked;
        @(posedge ref_clk) disable iff (rst)
        (!r.trigger_level_select && r.prev_low_any && !r.pending
         && !(wr_take && hit_scr)) |=> !r.pending;
    endproperty
    a_edge_blocked: assert property (p_edge_blocked)
        else $error("edge latched while another pin was low");

    property p_level_hold;
        @(posedge ref_clk) disable iff (rst)
        (r.trigger_level_select && low_any && !(wr_take && hit_scr))
            |=> r.pending;
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("level mode dropped request with a pin low");

    property p_level_clear;
        @(posedge ref_clk) disable iff (rst)
        (r.trigger_level_select && r.pending && ack_ev
         && !(wr_take && hit_scr && !wbyte[KWP_BIT_MODE]))
            ##1 (!low_any && !falling)[*2]
            |=> !r.pending;
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("level request not cleared after ack and release");

    property p_edge_ack;
        @(posedge ref_clk) disable iff (rst)
        (!r.trigger_level_select && ack_ev && !falling
         && !(wr_take && hit_scr)) |=> !r.pending;
    endproperty
    a_edge_ack: assert property (p_edge_ack)
        else $error("edge mode ack did not clear request");

    property p_ack_reads_zero;
        @(posedge ref_clk) disable iff (rst)
        (read && r.bus_ack && hit_scr)
            |-> (readdata[KWP_BIT_ACK] == 1'b0)
                && (readdata[7:4] == 4'h0);
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("ack bit or unused bits read nonzero");

    property p_flag_read;
        @(posedge ref_clk) disable iff (rst)
        (read && r.bus_ack && hit_scr)
            |-> readdata[KWP_BIT_FLAG] == $past(r.pending);
    endproperty
    a_flag_read: assert property (p_flag_read)
        else $error("pending flag read does not match latch");

    property p_mask_blocks;
        @(posedge ref_clk) disable iff (rst)
        r.irq_mask |-> !keypad_irq;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks)
        else $error("masked request reached the interrupt line");

    property p_break_protect;
        @(posedge ref_clk) disable iff (rst)
        (break_state && !break_clear_enable && r.pending
         && !vector_fetch_ack && wr_take && hit_scr) |=> r.pending;
    endproperty
    a_break_protect: assert property (p_break_protect)
        else $error("ack write cleared latch during protected break");

    property p_reset_state;
        @(posedge ref_clk)
        rst |=> !r.pending && !r.irq_mask && (r.pin_irq_enable == 8'h00)
                && (pin_pullup_enable == 8'hff);
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("reset state wrong");

    // register side effects; each write must touch only its own
    // register, so a stray decode shows up here long before it would
    // show up as a wrong pin level on the board

    // a pin enable write lands on the force outputs one edge later
    property p_force_follows;
        @(posedge ref_clk) disable iff (rst)
        (wr_take && hit_en) |=> (pin_input_force == $past(wbyte));
    endproperty
    a_force_follows: assert property (p_force_follows)
        else $error("pin enable write did not reach the force outputs");

    // pull-ups move only on their own register, never with an enable
    property p_pullup_untouched;
        @(posedge ref_clk) disable iff (rst)
        (wr_take && !hit_pu) |=> $stable(pin_pullup_enable);
    endproperty
    a_pullup_untouched: assert property (p_pullup_untouched)
        else $error("pull-up changed on a write to another register");

    // a zero written to a pull-up bit switches that pull-up off
    property p_pullup_write;
        @(posedge ref_clk) disable iff (rst)
        (wr_take && hit_pu) |=> (pin_pullup_enable == $past(wbyte));
    endproperty
    a_pullup_write: assert property (p_pullup_write)
        else $error("pull-up write did not take effect");

    // level mode bookkeeping: an ack seen with a key still down is
    // remembered, and without any ack a released key keeps the request;
    // a mode write in the same cycle is left out, it changes the rules

    // ack with a key still low is kept until the keys come back up
    property p_level_ack_memory;
        @(posedge ref_clk) disable iff (rst)
        (r.trigger_level_select && r.pending && ack_ev && low_any
         && !falling
         && !(wr_take && hit_scr && !wbyte[KWP_BIT_MODE]))
            |=> r.acked;
    endproperty
    a_level_ack_memory: assert property (p_level_ack_memory)
        else $error("level mode forgot an ack seen with a key low");

    // release alone never clears a level request
    property p_level_release_hold;
        @(posedge ref_clk) disable iff (rst)
        (r.trigger_level_select && r.pending && !r.acked && !ack_ev
         && !low_any && !falling && !(wr_take && hit_scr))
            |=> r.pending;
    endproperty
    a_level_release_hold: assert property (p_level_release_hold)
        else $error("level request cleared without an ack");

    // break handling: with clear allowed the ack write works as usual,
    // and a latch cleared in break stays clear when break ends

    // ack write in break with clear allowed drops an edge mode latch
    property p_break_clear;
        @(posedge ref_clk) disable iff (rst)
        (break_state && break_clear_enable && wr_take && hit_scr
         && wbyte[KWP_BIT_ACK] && !r.trigger_level_select
         && !falling) |=> !r.pending;
    endproperty
    a_break_clear: assert property (p_break_clear)
        else $error("ack write in break with clear allowed was lost");

    // leaving break does not bring back a cleared latch
    property p_break_stays;
        @(posedge ref_clk) disable iff (rst)
        ($fell(break_state) && !r.pending && !falling
         && !(r.trigger_level_select && low_any)) |=> !r.pending;
    endproperty
    a_break_stays: assert property (p_break_stays)
        else $error("latch came back when break ended");

    // wake paths: the latched one for wait, the raw one for stop,
    // where no clock edge would ever reach the latch

    // an unmasked latched request always asks for wake-up
    property p_wake_latched;
        @(posedge ref_clk) disable iff (rst)
        (!r.irq_mask && r.pending) |-> wakeup_req;
    endproperty
    a_wake_latched: assert property (p_wake_latched)
        else $error("unmasked request did not ask for wake-up");

    // an unmasked enabled raw pin low asks for wake-up before any latching
    property p_wake_raw;
        @(posedge ref_clk) disable iff (rst)
        (!r.irq_mask && (|(r.pin_irq_enable & ~key_pin_in)))
            |-> wakeup_req;
    endproperty
    a_wake_raw: assert property (p_wake_raw)
        else $error("raw key press did not ask for wake-up");

    // bus side: one wait state, then the answer, never a longer stall

    // a waiting request is answered on the very next cycle
    property p_one_wait;
        @(posedge ref_clk) disable iff (rst)
        (req && waitrequest) |=> (!waitrequest || !req);
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("register bus stalled for more than one wait state");

    // unused upper read lanes are always zero
    property p_read_upper_zero;
        @(posedge ref_clk) disable iff (rst)
        (read && r.bus_ack) |-> (readdata[31:8] == 24'h000000);
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero)
        else $error("upper read lanes not zero");

    c_edge_latch: cover property (@(posedge ref_clk) disable iff (rst)
        falling ##1 keypad_irq);
    c_level_hold: cover property (@(posedge ref_clk) disable iff (rst)
        r.trigger_level_select && r.acked && low_any);
    c_break_protect: cover property (@(posedge ref_clk) disable iff (rst)
        break_state && !break_clear_enable && wr_take && hit_scr
        && r.pending);
    c_read_scr: cover property (@(posedge ref_clk) disable iff (rst)
        read && r.bus_ack && hit_scr && readdata[KWP_BIT_FLAG]);
    // vector fetch taking the place of a software ack
    c_vector_ack: cover property (@(posedge ref_clk) disable iff (rst)
        vector_fetch_ack && r.pending ##1 !r.pending);

endmodule

// ===== verification/kwp_keys.sv
// key switch model for the port f keypad pins
`timescale 1ns/100ps
module kwp_keys (
    input  wire logic       ref_clk,
    input  wire logic [7:0] press,
    input  wire logic [7:0] pu_on,
    output logic      [7:0] pins
);
    logic flip = 1'b0;
    // a pin with no pull-up and no key floats; it toggles so that
    // no stale level can pass for a real one
    always @(posedge ref_clk) begin
        flip <= ~flip;
    end
    // a pressed key pulls low, a released key follows its pull-up
    assign pins = ~press & (pu_on | {8{flip}});
endmodule

// ===== verification/tb_keypad_wakeup_interrupt_port_f.sv
// self-checking bench for the port f keypad interrupt block
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module tb_keypad_wakeup_interrupt_port_f
    import kwp_pkg::*;
;
    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [KWP_ADDR_W-1:0] address = '0;
    logic                  read = 1'b0;
    logic                  write = 1'b0;
    logic [KWP_DATA_W-1:0] writedata = '0;
    logic [3:0]            byteenable = 4'hf;
    logic [KWP_DATA_W-1:0] readdata;
    logic                  waitrequest;
    logic [7:0]            pins;
    logic [7:0]            force_in;
    logic [7:0]            pu_en;
    logic [7:0]            press = 8'h00;
    logic                  brk = 1'b0;
    logic                  bce = 1'b0;
    logic                  vfa = 1'b0;
    logic                  irq;
    logic                  wake;
    logic [31:0]           rd;
    int                    err_count = 0;
    int                    num_checks = 0;

    kwp_top uut (.ref_clk(ref_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .key_pin_in(pins),
        .pin_input_force(force_in), .pin_pullup_enable(pu_en),
        .break_state(brk), .break_clear_enable(bce),
        .vector_fetch_ack(vfa), .keypad_irq(irq), .wakeup_req(wake));
    kwp_keys keys (.ref_clk(ref_clk), .press(press), .pu_on(pu_en),
        .pins(pins));

    // 200 mhz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // let n edges pass, then look at settled outputs mid-cycle
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // one avalon transfer; sampling at the falling edge sees the value
    // that the next rising edge takes, without racing the design
    task automatic bus(input logic wr_n, input logic [7:0] idx,
                       input logic [7:0] d);
        logic w;
        int   n;
        w = 1'b1;
        n = 0;
        @(posedge ref_clk);
        address   <= {idx, 2'b00};
        writedata <= {24'h0, d};
        write     <= wr_n;
        read      <= ~wr_n;
        while (w && n < 20) begin
            @(negedge ref_clk);
            w = waitrequest;
            rd = readdata;
            n++;
            @(posedge ref_clk);
        end
        write <= 1'b0;
        read  <= 1'b0;
        if (w) begin
            err_count++;
            complete_run();
        end
        @(negedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
        bus(1'b0, idx, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask

    // latch path is three cycles from the pin; one spare
    task automatic keys_to(input logic [7:0] p);
        @(posedge ref_clk);
        press <= p;
        cyc(4);
    endtask

    task automatic t_reset();
        `CHK(force_in, KWP_RST_PIN_ENABLE)
        `CHK(pu_en, KWP_RST_PULLUP)
        `CHK({irq, wake}, 2'b00)
        rchk(KWP_IDX_STATUS_CONTROL, 8'h00);
        rchk(KWP_IDX_PIN_ENABLE, 8'h00);
        rchk(KWP_IDX_PULLUP_ENABLE, 8'hff);
        rchk(8'h43, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_regs();
        wr(KWP_IDX_PULLUP_ENABLE, 8'h0f);
        `CHK(pu_en, 8'h0f)
        wr(KWP_IDX_PULLUP_ENABLE, 8'hff);
        wr(KWP_IDX_PIN_ENABLE, 8'h5a);
        `CHK(force_in, 8'h5a)
        `CHK(pu_en, 8'hff)
        // no low byte lane, or a hole in the map: nothing may change
        @(posedge ref_clk);
        byteenable <= 4'he;
        wr(KWP_IDX_PIN_ENABLE, 8'hff);
        @(posedge ref_clk);
        byteenable <= 4'hf;
        wr(8'h43, 8'hff);
        rchk(KWP_IDX_PIN_ENABLE, 8'h5a);
        wr(KWP_IDX_STATUS_CONTROL, 8'hf3);
        rchk(KWP_IDX_STATUS_CONTROL, 8'h03);
        wr(KWP_IDX_STATUS_CONTROL, 8'h04);
        rchk(KWP_IDX_STATUS_CONTROL, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_edge();
        wr(KWP_IDX_PIN_ENABLE, 8'hff);
        keys_to(8'h01);
        `CHK({irq, wake}, 2'b11)
        rchk(KWP_IDX_STATUS_CONTROL, 8'h08);
        wr(KWP_IDX_STATUS_CONTROL, 8'h04);
        `CHK(irq, 1'b0)
        keys_to(8'h03);
        `CHK(irq, 1'b0)
        keys_to(8'h00);
        keys_to(8'h04);
        `CHK(irq, 1'b1)
        @(posedge ref_clk);
        vfa <= 1'b1;
        @(posedge ref_clk);
        vfa <= 1'b0;
        cyc(0);
        `CHK(irq, 1'b0)
        keys_to(8'h00);
        $display("test edge done");
    endtask

    // both clearing orders in level mode
    task automatic t_level();
        wr(KWP_IDX_STATUS_CONTROL, 8'h05);
        wr(KWP_IDX_PIN_ENABLE, 8'h08);
        keys_to(8'h08);
        wr(KWP_IDX_STATUS_CONTROL, 8'h05);
        `CHK(irq, 1'b1)
        keys_to(8'h00);
        `CHK(irq, 1'b0)
        keys_to(8'h08);
        keys_to(8'h00);
        `CHK(irq, 1'b1)
        wr(KWP_IDX_STATUS_CONTROL, 8'h05);
        cyc(1);
        `CHK(irq, 1'b0)
        $display("test level done");
    endtask

    task automatic t_mask();
        wr(KWP_IDX_STATUS_CONTROL, 8'h06);
        wr(KWP_IDX_PIN_ENABLE, 8'hff);
        keys_to(8'h10);
        `CHK({irq, wake}, 2'b00)
        rchk(KWP_IDX_STATUS_CONTROL, 8'h0a);
        wr(KWP_IDX_STATUS_CONTROL, 8'h00);
        `CHK({irq, wake}, 2'b11)
        wr(KWP_IDX_STATUS_CONTROL, 8'h04);
        `CHK({irq, wake}, 2'b01)
        keys_to(8'h00);
        $display("test mask done");
    endtask

    task automatic t_break();
        keys_to(8'h20);
        @(posedge ref_clk);
        brk <= 1'b1;
        wr(KWP_IDX_STATUS_CONTROL, 8'h04);
        `CHK(irq, 1'b1)
        @(posedge ref_clk);
        bce <= 1'b1;
        wr(KWP_IDX_STATUS_CONTROL, 8'h04);
        `CHK(irq, 1'b0)
        @(posedge ref_clk);
        brk <= 1'b0;
        bce <= 1'b0;
        cyc(1);
        `CHK(irq, 1'b0)
        keys_to(8'h00);
        $display("test break done");
    endtask

    // reset with a key held down must still drop the request
    task automatic t_rst();
        keys_to(8'h01);
        `CHK(irq, 1'b1)
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        rst <= 1'b0;
        cyc(1);
        `CHK({irq, force_in}, 9'h000)
        rchk(KWP_IDX_STATUS_CONTROL, 8'h00);
        $display("test reset2 done");
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(0);
        t_reset();
        t_regs();
        t_edge();
        t_level();
        t_mask();
        t_break();
        t_rst();
        complete_run();
    end
endmodule
